//--- rtl/list_ptr_bank.sv
// Control current and bulk head list-pointer registers.
// Assumes one clock, plain register port, list processor on mclk.
`timescale 1ns/1ps
`include "list_ptr_regs.svh"

// Operation
// - Advance control pointer after serving descriptor
// - Resume control list where previous frame stopped
// - At list end, test filled flag
// - Flag set: reload from head, clear flag
// - Enabled: reads return live pointer value
// - Pointer starts zero; zero means end
// - Address bits 31:4, low bits reserved
// - Current pointer readable at offset 24h
// - Bulk traversal starts at bulk head
// - Bulk head loaded from communication area
// - Bulk head read-write at 28h, reset zero
module list_ptr_bank
  import list_ptr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Control register and command status view
  input wire logic ctrl_list_enable,
  input wire logic control_list_filled_flag,
  output logic filled_flag_clear,
  // List processor side
  input wire logic ctrl_ed_done,
  input wire logic [31:0] ctrl_next_ed,
  input wire logic init_load,
  input wire logic [31:0] init_bulk_head,
  // Pointer outputs and list-end flag
  output logic [31:0] control_list_head_pointer,
  output logic [31:0] bulk_walk_start,
  output logic control_list_end
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire sel_cur = hit(reg_addr, `CTRL_CUR_PTR_OFFSET);
  wire sel_bulk = hit(reg_addr, `BULK_HEAD_PTR_OFFSET);
  wire sel_head = hit(reg_addr, `CTRL_HEAD_PTR_OFFSET);
  wire sel_stat = hit(reg_addr, `LIST_STATUS_OFFSET);

  // ****************************************
  // Storage
  // ****************************************
  ptr_field_t bulk_head;
  ptr_field_t ctrl_head;
  ptr_field_t cur_ptr;
  logic filled_clear;
  logic list_end;

  // Current-pointer writes while the list runs are dropped, not queued
  wire cur_wr = reg_wr && sel_cur && !ctrl_list_enable;
  // Low bits discarded so reserved bits never store
  wire [27:0] wr_field = reg_wdata[`PTR_ADDR_MSB:`PTR_ADDR_LSB];
  wire [27:0] next_bulk = init_load ? init_bulk_head[`PTR_ADDR_MSB:`PTR_ADDR_LSB] :
                          (reg_wr && sel_bulk) ? wr_field : bulk_head;
  wire [27:0] next_head = (reg_wr && sel_head) ? wr_field : ctrl_head;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bulk_head <= 28'h0000000;
      ctrl_head <= 28'h0000000;
    end
    else
    begin
      bulk_head <= next_bulk;
      ctrl_head <= next_head;
    end
  end

  // ****************************************
  // Control list walker
  // ****************************************
  list_ptr_walk u_walk (
    .mclk(mclk),
    .rst_n(rst_n),
    .ed_done(ctrl_ed_done && ctrl_list_enable),
    .next_ed(ctrl_next_ed[`PTR_ADDR_MSB:`PTR_ADDR_LSB]),
    .sw_write(cur_wr),
    .sw_value(wr_field),
    .filled_flag(control_list_filled_flag && ctrl_list_enable),
    .head_ptr(ctrl_head),
    .cur_ptr(cur_ptr),
    .filled_clear(filled_clear),
    .list_end(list_end)
  );

  // ****************************************
  // Read data
  // ****************************************
  // Live pointer, no snapshot, so a read sees the walk as it is
  wire [31:0] next_rdata = sel_cur ? {cur_ptr, 4'h0} :
                           sel_bulk ? {bulk_head, 4'h0} :
                           sel_head ? {ctrl_head, 4'h0} :
                           sel_stat ? {30'h0, list_end, ctrl_list_enable} :
                           `UNMAPPED_READ;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= `PTR_RESET;
      filled_flag_clear <= 1'b0;
      control_list_head_pointer <= `PTR_RESET;
      bulk_walk_start <= `PTR_RESET;
      control_list_end <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : `UNMAPPED_READ;
      filled_flag_clear <= filled_clear;
      control_list_head_pointer <= {cur_ptr, 4'h0};
      bulk_walk_start <= {bulk_head, 4'h0};
      control_list_end <= list_end;
    end
  end

endmodule // list_ptr_bank

//--- rtl/list_ptr_pkg.sv
// Types for the list-pointer bank.
// Assumes list_ptr_regs.svh is on the include path.
package list_ptr_pkg;
  typedef logic [31:0] word_t;
  typedef logic [27:0] ptr_field_t;
  typedef enum logic [1:0] {
    walk_idle,
    walk_serve,
    walk_end
  } walk_state_t;
endpackage

//--- rtl/list_ptr_regs.svh
// Register offsets, fields, reset values for the list-pointer bank.
// Assumes a 32-bit plain register port with byte addresses.
`ifndef LIST_PTR_REGS_SVH
`define LIST_PTR_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define CTRL_CUR_PTR_OFFSET 8'h24
`define BULK_HEAD_PTR_OFFSET 8'h28
`define CTRL_HEAD_PTR_OFFSET 8'h20
`define LIST_STATUS_OFFSET 8'h40

// ****************************************
// Fields and reset values
// ****************************************
`define PTR_ADDR_MSB 31
`define PTR_ADDR_LSB 4
`define PTR_RESET 32'h00000000
`define CMD_STATUS_FILLED_BIT 1
`define CTRL_LIST_ENABLE_BIT 4
`define UNMAPPED_READ 32'h00000000

`endif

//--- rtl/list_ptr_walk.sv
// Control-list walker: advances and reloads the current pointer.
// Assumes the list processor supplies one-cycle event pulses.
`timescale 1ns/1ps
`include "list_ptr_regs.svh"

module list_ptr_walk
  import list_ptr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Events and values from the list processor and the registers
  input wire logic ed_done,
  input wire logic [27:0] next_ed,
  input wire logic sw_write,
  input wire logic [27:0] sw_value,
  input wire logic filled_flag,
  input wire logic [27:0] head_ptr,
  // Results
  output logic [27:0] cur_ptr,
  output logic filled_clear,
  output logic list_end
);

  // ****************************************
  // Pointer update
  // ****************************************
  wire at_end = (cur_ptr == 28'h0000000);
  wire reload = at_end && filled_flag && !sw_write;
  wire [27:0] next_cur = sw_write ? sw_value :
                         reload ? head_ptr :
                         (ed_done && !at_end) ? next_ed : cur_ptr;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ptr <= 28'h0000000;
      filled_clear <= 1'b0;
      list_end <= 1'b0;
    end
    else
    begin
      cur_ptr <= next_cur;
      filled_clear <= reload;
      list_end <= at_end && !filled_flag;
    end
  end

endmodule // list_ptr_walk

//--- verification/list_flag_owner.sv
// Model of the command-status filled flag owner.
// Assumes set and clear pulses on mclk.
`timescale 1ns/1ps
module list_flag_owner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Set by software, cleared by the bank
  input wire logic set_flag,
  input wire logic filled_flag_clear,
  output logic control_list_filled_flag
);
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      control_list_filled_flag <= 1'b0;
    else if (set_flag)
      control_list_filled_flag <= 1'b1;
    else if (filled_flag_clear)
      control_list_filled_flag <= 1'b0;
endmodule // list_flag_owner

//--- verification/list_ptr_bank_sva.sv
// Checker: port relations of the list-pointer bank.
// Assumes binding to list_ptr_bank, one clock domain.
`timescale 1ns/1ps
module list_ptr_bank_sva (
  // All ports of the bank, watched only
  input wire logic mclk, rst_n, reg_wr, reg_rd, ctrl_list_enable, control_list_filled_flag,
  input wire logic ctrl_ed_done, init_load, filled_flag_clear, control_list_end,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata, ctrl_next_ed, init_bulk_head, reg_rdata,
  input wire logic [31:0] control_list_head_pointer, bulk_walk_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Mirror lags the live pointer by one cycle, so checks look two edges on
  wire reload_seen = control_list_head_pointer == '0 && control_list_filled_flag &&
    ctrl_list_enable && !reg_wr;
  sequence s_reload;
    reload_seen && $past(control_list_head_pointer) == '0 && !$past(reload_seen);
  endsequence
  sequence s_clear;
    ##2 filled_flag_clear;
  endsequence
  a_reload_clear: assert property (s_reload |-> s_clear)
    else $error("flag clear missing");
  a_clear_cause: assert property (filled_flag_clear |-> $past(control_list_filled_flag, 2))
    else $error("clear without flag");
  a_advance_next: assert property (ctrl_ed_done && ctrl_list_enable && !reg_wr &&
    control_list_head_pointer != '0 && !$past(ctrl_ed_done) &&
    !$past(control_list_filled_flag) && !$past(reg_wr) |->
    ##2 control_list_head_pointer == ($past(ctrl_next_ed, 2) & 32'hfffffff0))
    else $error("pointer not advanced");
  a_hold_idle: assert property (!ctrl_ed_done && !reg_wr && !control_list_filled_flag
    |-> ##2 $stable(control_list_head_pointer))
    else $error("pointer moved alone");
  a_write_refused: assert property (reg_wr && ctrl_list_enable && !ctrl_ed_done &&
    !control_list_filled_flag |-> ##2 $stable(control_list_head_pointer))
    else $error("write taken while enabled");
  a_read_live: assert property (reg_rd && reg_addr == 8'h24
    |=> reg_rdata == control_list_head_pointer)
    else $error("current read wrong");
  a_bulk_write: assert property (reg_wr && reg_addr == 8'h28 && !init_load
    |-> ##2 bulk_walk_start == ($past(reg_wdata, 2) & 32'hfffffff0))
    else $error("bulk write wrong");
  a_bulk_init: assert property (init_load
    |-> ##2 bulk_walk_start == ($past(init_bulk_head, 2) & 32'hfffffff0))
    else $error("bulk init wrong");
  a_low_zero: assert property (control_list_head_pointer[3:0] == 4'h0 &&
    bulk_walk_start[3:0] == 4'h0)
    else $error("low bits set");
endmodule // list_ptr_bank_sva

bind list_ptr_bank list_ptr_bank_sva i_list_ptr_bank_sva (.*);

//--- verification/tb_control_bulk_list_pointers.sv
// Bench: register port, walker events, reload.
// Assumes the flag owner model beside the bank.
`timescale 1ns/1ps
module tb_control_bulk_list_pointers;
  import list_ptr_pkg::*;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, en = 0, done = 0, init = 0, setf = 0;
  logic flag, fclr, lend;
  logic [7:0] addr = 8'h00;
  word_t wdata = '0, nxt = '0, ival = '0, rdata, cur, bulk, r;
  int bad_count = 0, total_checks = 0;
  always #5 mclk = ~mclk;
  list_ptr_bank i_list_ptr_bank (.mclk, .rst_n, .reg_addr(addr), .reg_wdata(wdata), .reg_wr,
    .reg_rd, .reg_rdata(rdata), .ctrl_list_enable(en), .control_list_filled_flag(flag),
    .filled_flag_clear(fclr), .ctrl_ed_done(done), .ctrl_next_ed(nxt), .init_load(init),
    .init_bulk_head(ival), .control_list_head_pointer(cur), .bulk_walk_start(bulk),
    .control_list_end(lend));
  list_flag_owner i_list_flag_owner (.mclk, .rst_n, .set_flag(setf), .filled_flag_clear(fclr),
    .control_list_filled_flag(flag));
  function automatic word_t al(word_t w);
    return w & 32'hfffffff0;
  endfunction
  task automatic chk(string what, word_t exp, word_t got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // Read when w is low: d is then the expected word
  // Idle edge at the end so no strobe is set twice in one step
  task automatic bus(logic [7:0] a, word_t d, logic w);
    addr <= a;
    wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    tick();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (!w) chk("rdata", d, rdata);
    tick();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    r = $urandom(32'hb881);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(8'h24, '0, 0);
    bus(8'h28, '0, 0);
    bus(8'h3c, '0, 0);
    repeat (6)
    begin
      r = $urandom;
      bus(8'h28, al(r), 1);
      bus(8'h28, al(r), 0);
      ival <= $urandom;
      init <= 1'b1;
      tick();
      init <= 1'b0;
      tick();
      chk("bulk", al(ival), bulk);
    end
    bus(8'h20, 32'h00000a50, 1);
    bus(8'h24, 32'h00001234, 1);
    en <= 1'b1;
    bus(8'h24, 32'h00005678, 1);
    bus(8'h24, 32'h00001230, 0);
    repeat (4)
    begin
      nxt <= $urandom | 32'h10;
      done <= 1'b1;
      tick();
      done <= 1'b0;
      tick();
      chk("cur", al(nxt), cur);
    end
    nxt <= '0;
    done <= 1'b1;
    tick();
    done <= 1'b0;
    repeat (3) tick();
    chk("end", 32'h1, {31'h0, lend});
    bus(8'h40, 32'h00000003, 0);
    setf <= 1'b1;
    tick();
    setf <= 1'b0;
    repeat (3) tick();
    chk("flag", '0, {31'h0, flag});
    bus(8'h24, 32'h00000a50, 0);
    bus(8'h40, 32'h00000001, 0);
    stop_test();
  end
endmodule // tb_control_bulk_list_pointers
